// >>> rtl/csb_pkg.sv
// csb_pkg: constants, types and offset decoding for the chip setup bank
// assumes a 4 KB register page selected by the bus fabric through HSEL
`default_nettype none
package csb_pkg;
   // number of read-write setup words
   localparam int unsigned CSB_NUM_RW = 3;
   // byte offsets within the page
   localparam logic [11:0] CSB_OFF_CLKDIV = 12'h000;
   localparam logic [11:0] CSB_OFF_REMAP = 12'h004;
   localparam logic [11:0] CSB_OFF_BOOT = 12'h008;
   localparam logic [11:0] CSB_OFF_STATUS = 12'h010;
   // values after reset
   localparam logic [31:0] CSB_RST_CLKDIV = 32'hBB8A802A;
   localparam logic [31:0] CSB_RST_REMAP = 32'h00001F09;
   localparam logic [31:0] CSB_RST_BOOT = 32'h00000000;
   localparam logic [31:0] CSB_RST_STATUS = 32'h00000000;
   localparam logic [CSB_NUM_RW-1:0][31:0] CSB_RST_VALS = {CSB_RST_BOOT, CSB_RST_REMAP, CSB_RST_CLKDIV};
   // status word bit positions
   localparam int unsigned CSB_ST_RUN = 0;
   localparam int unsigned CSB_ST_UNUSED_WR = 1;
   localparam int unsigned CSB_ST_NARROW_WR = 2;
   localparam int unsigned CSB_ST_RO_WR = 3;
   localparam int unsigned CSB_ST_LOAD_FAIL = 4;
   // slot one-hot positions: three setup words then status
   localparam int unsigned CSB_SLOT_STATUS = 3;
   // bus encodings
   localparam logic [2:0] CSB_HSIZE_WORD = 3'h2;
   localparam logic [1:0] CSB_HTRANS_NONSEQ = 2'h2;
   localparam logic CSB_HRESP_OKAY = 1'h0;

   // a word of the bank
   typedef logic [31:0] csb_word_t;
   // one access to be decoded
   typedef struct packed {
      logic valid;
      logic write;
      logic word;
      logic [11:0] offset;
   } csb_req_s;
   // outcome of a decoded access
   typedef struct packed {
      logic [CSB_NUM_RW:0] slot;
      logic [CSB_NUM_RW-1:0] we;
      logic unused_wr;
      logic narrow_wr;
      logic ro_wr;
   } csb_dec_s;
   // bank phase: loading before chip release, then running
   typedef enum logic {CSB_LOAD, CSB_RUN} csb_phase_e;

   // word offset to one-hot slot, zero for an unpopulated word
   function automatic logic [CSB_NUM_RW:0] csb_slot(input logic [11:0] off);
      logic [CSB_NUM_RW:0] s;
      s = '0;
      unique case ({off[11:2], 2'h0})
         CSB_OFF_CLKDIV: s = 4'h1;
         CSB_OFF_REMAP: s = 4'h2;
         CSB_OFF_BOOT: s = 4'h4;
         CSB_OFF_STATUS: s = 4'h8;
         default: s = 4'h0;
      endcase
      return s;
   endfunction : csb_slot
endpackage : csb_pkg
`default_nettype wire

// >>> rtl/csb_decode.sv
// csb_decode: classifies one access against the bank map
// assumes the request comes from logic on the same clock
`default_nettype none
module csb_decode
   import csb_pkg::*;
(
   input wire csb_req_s req,
   output csb_dec_s dec
);
   // slot hit by the offset
   wire [CSB_NUM_RW:0] slot = csb_slot(req.offset);
   // a live write of any kind
   wire is_wr = req.valid & req.write;
   // a write that may land in a setup word
   wire wr_ok = is_wr & req.word;

   // decoded outcome
   assign dec.slot = slot;
   assign dec.we = wr_ok ? slot[CSB_NUM_RW-1:0] : '0;
   assign dec.unused_wr = is_wr & (slot == '0);
   assign dec.narrow_wr = is_wr & ~req.word & (slot != '0);
   assign dec.ro_wr = is_wr & slot[CSB_SLOT_STATUS];
endmodule : csb_decode
`default_nettype wire

// >>> rtl/csb_cfg_word.sv
// csb_cfg_word: one read-write setup word with a fixed reset value
// assumes the write enable is a single-cycle strobe on CLK
`default_nettype none
module csb_cfg_word
   import csb_pkg::*;
#(
   parameter csb_word_t RESET_VALUE = '0
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic we,
   input wire csb_word_t wdata,
   output csb_word_t q,
   output csb_word_t nxt_q
);
   // stored word
   csb_word_t word_ff;
   // value after this edge, used for read forwarding
   assign nxt_q = we ? wdata : word_ff;
   assign q = word_ff;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         word_ff <= RESET_VALUE;
      end else begin
         word_ff <= nxt_q;
      end
   end
endmodule : csb_cfg_word
`default_nettype wire

// >>> rtl/csb_chip_setup.sv
// csb_chip_setup: chip setup register bank, AHB-Lite slave plus load port
// assumes the board controller drives the load port from logic on CLK
// assumes HSEL already decodes the 4 KB page; zero wait states
`default_nettype none

// Functional notes
// - only whole aligned word bus writes update; load port writes are whole words with the low offset bits ignored
// - writes to read-only status are dropped
// - unpopulated word writes fail, no setup word changes, only the status unused-write bit (bus) or load-fail bit (load port) is set
// - reads return the full 32-bit word
// - unpopulated word reads return zero
// - clock divider word at 0x000
// - remap and misc word at 0x004
// - boot option word at 0x008
// - loaded values readable after reset ends
module csb_chip_setup
   import csb_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic HREADY,
   input wire logic [31:0] HWDATA,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic CFG_LOAD_VALID,
   input wire logic [11:0] CFG_LOAD_OFFSET,
   input wire logic [31:0] CFG_LOAD_DATA,
   output logic CFG_LOAD_READY,
   input wire logic CFG_LOAD_DONE,
   output logic CHIP_RUN,
   output logic [31:0] CLOCK_DIVIDER_SETUP,
   output logic [31:0] REMAP_AND_MISC_SETUP,
   output logic [31:0] BOOT_OPTION_SETUP
);

   // ------------------------------------------------------------
   // address phase
   // ------------------------------------------------------------

   // transfer accepted this edge
   wire ahb_take = HSEL & HTRANS[1] & HREADY;
   // accepted transfer is a read
   wire ahb_rd_take = ahb_take & ~HWRITE;
   // whole word, aligned: the only write that may land
   wire ahb_word = (HSIZE == CSB_HSIZE_WORD) & (HADDR[1:0] == 2'h0);
   // slot addressed by a read, byte lane bits dropped
   wire [CSB_NUM_RW:0] rd_slot = csb_slot(HADDR[11:0]);

   // captured address phase
   csb_req_s dph_ff;
   // next captured address phase
   csb_req_s nxt_dph;

   // next data phase request
   always_comb begin
      nxt_dph = '0;
      // a new transfer replaces the old one
      if (ahb_take) begin
         nxt_dph.valid = 1'b1;
         nxt_dph.write = HWRITE;
         nxt_dph.word = ahb_word;
         nxt_dph.offset = HADDR[11:0];
      end
   end

   // data phase register
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         dph_ff <= '0;
      end else begin
         dph_ff <= nxt_dph;
      end
   end

   // ------------------------------------------------------------
   // decoding of bus writes and load writes
   // ------------------------------------------------------------

   // decoded bus data phase
   csb_dec_s ahb_dec;
   // decoded load request
   csb_dec_s load_dec;
   // load request as a write access
   csb_req_s load_req;

   // bus data phase decode
   csb_decode u_ahb_dec (
      .req (dph_ff),
      .dec (ahb_dec)
   );

   // a bus write in data phase holds off the load port
   wire ahb_wr_busy = dph_ff.valid & dph_ff.write;

   // bank phase state
   csb_phase_e phase_ff;
   // next bank phase
   csb_phase_e nxt_phase;

   assign CFG_LOAD_READY = (phase_ff == CSB_LOAD) & ~ahb_wr_busy;
   // load taken this edge
   wire load_take = CFG_LOAD_VALID & CFG_LOAD_READY;

   // load is always a whole word write
   always_comb begin
      load_req = '0;
      load_req.valid = load_take;
      load_req.write = 1'b1;
      load_req.word = 1'b1;
      load_req.offset = CFG_LOAD_OFFSET;
   end

   // load port decode
   csb_decode u_load_dec (
      .req (load_req),
      .dec (load_dec)
   );

   // ------------------------------------------------------------
   // setup words
   // ------------------------------------------------------------

   // stored words
   csb_word_t cfg_q [CSB_NUM_RW];
   // words after this edge
   csb_word_t cfg_nxt [CSB_NUM_RW];
   // combined enables; bus and load never collide
   wire [CSB_NUM_RW-1:0] cfg_we = ahb_dec.we | load_dec.we;
   // bus write data wins when a bus write lands
   wire csb_word_t cfg_wdata = (ahb_dec.we != '0) ? HWDATA : CFG_LOAD_DATA;

   genvar gi;
   generate
      for (gi = 0; gi < CSB_NUM_RW; gi++) begin : g_word
         // one word, own reset value
         csb_cfg_word #(
            .RESET_VALUE (CSB_RST_VALS[gi])
         ) u_word (
            .clk (CLK),
            .nrst (NRST),
            .we (cfg_we[gi]),
            .wdata (cfg_wdata),
            .q (cfg_q[gi]),
            .nxt_q (cfg_nxt[gi])
         );
      end
   endgenerate

   // words drive the clock generators and boot logic
   assign CLOCK_DIVIDER_SETUP = cfg_q[0];
   assign REMAP_AND_MISC_SETUP = cfg_q[1];
   assign BOOT_OPTION_SETUP = cfg_q[2];

   // ------------------------------------------------------------
   // bank phase: hold the chip until loading is done
   // ------------------------------------------------------------

   // phase transition
   always_comb begin
      nxt_phase = phase_ff;
      unique case (phase_ff)
         // wait for the controller to finish
         CSB_LOAD: begin
            if (CFG_LOAD_DONE & ~CFG_LOAD_VALID) begin
               nxt_phase = CSB_RUN;
            end
         end
         // stays until the next reset
         CSB_RUN: begin
            nxt_phase = CSB_RUN;
         end
      endcase
   end

   // phase register and release output
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         phase_ff <= CSB_LOAD;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   assign CHIP_RUN = (phase_ff == CSB_RUN);

   // ------------------------------------------------------------
   // status word: read-only, sticky error bits cleared by reading
   // ------------------------------------------------------------

   // sticky error bits
   logic [CSB_ST_LOAD_FAIL:CSB_ST_UNUSED_WR] sticky_ff;
   // next sticky bits
   logic [CSB_ST_LOAD_FAIL:CSB_ST_UNUSED_WR] nxt_sticky;
   // events seen this cycle
   logic [CSB_ST_LOAD_FAIL:CSB_ST_UNUSED_WR] st_set;
   // read of status clears the sticky bits held before this cycle
   wire st_clr = ahb_rd_take & rd_slot[CSB_SLOT_STATUS];

   // collect this cycle's failed accesses
   always_comb begin
      st_set = '0;
      st_set[CSB_ST_UNUSED_WR] = ahb_dec.unused_wr;
      st_set[CSB_ST_NARROW_WR] = ahb_dec.narrow_wr;
      st_set[CSB_ST_RO_WR] = ahb_dec.ro_wr;
      st_set[CSB_ST_LOAD_FAIL] = load_dec.unused_wr | load_dec.ro_wr;
   end

   // set beats clear in the same cycle
   assign nxt_sticky = (st_clr ? '0 : sticky_ff) | st_set;

   // sticky register
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         sticky_ff <= CSB_RST_STATUS[CSB_ST_LOAD_FAIL:CSB_ST_UNUSED_WR];
      end else begin
         sticky_ff <= nxt_sticky;
      end
   end

   // status word as read, with this cycle's events included
   csb_word_t status_rd;
   always_comb begin
      status_rd = '0;
      status_rd[CSB_ST_RUN] = (nxt_phase == CSB_RUN);
      status_rd[CSB_ST_LOAD_FAIL:CSB_ST_UNUSED_WR] = sticky_ff | st_set;
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------

   // read data register
   csb_word_t rdata_ff;
   // selected read word
   csb_word_t rd_word;

   // select read word from values after this edge
   always_comb begin
      rd_word = '0;
      if (rd_slot[0]) begin
         rd_word = cfg_nxt[0];
      end else if (rd_slot[1]) begin
         rd_word = cfg_nxt[1];
      end else if (rd_slot[2]) begin
         rd_word = cfg_nxt[2];
      end else if (rd_slot[CSB_SLOT_STATUS]) begin
         rd_word = status_rd;
      end else begin
         rd_word = '0;
      end
   end

   // capture read data for the data phase
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rdata_ff <= '0;
      end else if (ahb_rd_take) begin
         rdata_ff <= rd_word;
      end else begin
         rdata_ff <= '0;
      end
   end

   // ------------------------------------------------------------
   // bus response
   // ------------------------------------------------------------

   // zero wait states, always OKAY
   assign HREADYOUT = 1'b1;
   assign HRESP = CSB_HRESP_OKAY;
   assign HRDATA = rdata_ff;

endmodule : csb_chip_setup
`default_nettype wire

// >>> tb/csb_chip_setup_monitor.sv
// csb_chip_setup_monitor: bus and bank checks on the top ports
// assumes one clock, NRST async low, bound into csb_chip_setup
`default_nettype none
module csb_chip_setup_monitor
   import csb_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic HREADY,
   input wire logic [31:0] HWDATA,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic CFG_LOAD_READY,
   input wire logic CHIP_RUN,
   input wire logic [31:0] CLOCK_DIVIDER_SETUP,
   input wire logic [31:0] REMAP_AND_MISC_SETUP,
   input wire logic [31:0] BOOT_OPTION_SETUP
);
   logic rd_ph; // read data phase
   logic wr_ph; // write data phase
   logic [11:0] a_q; // offset in data phase
   logic [2:0] s_q; // size in data phase
   wire full = s_q == CSB_HSIZE_WORD && a_q[1:0] == 2'h0; // whole aligned word
   wire bank = a_q[11:4] == 8'h00 && a_q[3:2] != 2'h3; // one of three words
   wire unused = !bank && a_q[11:2] != 10'h004; // neither word nor status
   wire [95:0] words = {BOOT_OPTION_SETUP, REMAP_AND_MISC_SETUP, CLOCK_DIVIDER_SETUP};
   // capture of each accepted address phase
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rd_ph <= 1'b0;
         wr_ph <= 1'b0;
         a_q <= '0;
         s_q <= '0;
      end else begin
         rd_ph <= HSEL && HTRANS[1] && HREADY && !HWRITE;
         wr_ph <= HSEL && HTRANS[1] && HREADY && HWRITE;
         a_q <= HADDR[11:0];
         s_q <= HSIZE;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   property p_okay;
      HREADYOUT && HRESP == CSB_HRESP_OKAY;
   endproperty
   a_okay: assert property (p_okay) else $error("bus not ready or not okay");
   property p_rd_idle;
      !rd_ph |-> HRDATA == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
   property p_rd_word;
      rd_ph && a_q == CSB_OFF_CLKDIV |-> HRDATA == CLOCK_DIVIDER_SETUP;
   endproperty
   a_rd_word: assert property (p_rd_word) else $error("read data not the stored word");
   property p_rd_unused;
      rd_ph && unused |-> HRDATA == '0;
   endproperty
   a_rd_unused: assert property (p_rd_unused) else $error("unused word read not zero");
   property p_wr_full;
      wr_ph && full && a_q == CSB_OFF_CLKDIV |=> CLOCK_DIVIDER_SETUP == $past(HWDATA);
   endproperty
   a_wr_full: assert property (p_wr_full) else $error("word write not stored");
   property p_wr_narrow;
      wr_ph && !full |=> $stable(words);
   endproperty
   a_wr_narrow: assert property (p_wr_narrow) else $error("narrow write changed a word");
   property p_wr_off;
      wr_ph && !bank |=> $stable(words);
   endproperty
   a_wr_off: assert property (p_wr_off) else $error("write off the words changed one");
   property p_rst;
      !$past(NRST) |-> words == CSB_RST_VALS && !CHIP_RUN;
   endproperty
   a_rst: assert property (p_rst) else $error("value after reset wrong");
   property p_closed;
      $past(CHIP_RUN) |-> CHIP_RUN && !CFG_LOAD_READY;
   endproperty
   a_closed: assert property (p_closed) else $error("load port open after release");
endmodule : csb_chip_setup_monitor

bind csb_chip_setup csb_chip_setup_monitor u_mon (
   .CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HSIZE(HSIZE), .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP), .CFG_LOAD_READY(CFG_LOAD_READY), .CHIP_RUN(CHIP_RUN),
   .CLOCK_DIVIDER_SETUP(CLOCK_DIVIDER_SETUP), .REMAP_AND_MISC_SETUP(REMAP_AND_MISC_SETUP),
   .BOOT_OPTION_SETUP(BOOT_OPTION_SETUP)
);
`default_nettype wire

// >>> tb/csb_board_ctrl_model.sv
// csb_board_ctrl_model: board controller loading the bank before release
// assumes the load handshake on clk; go held high by the bench
`default_nettype none
module csb_board_ctrl_model
   import csb_pkg::*;
#(
   parameter logic [2:0][31:0] WORDS = '0
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic go,
   input wire logic slow,
   input wire logic ready,
   output logic valid,
   output logic [11:0] offset,
   output logic [31:0] data,
   output logic done
);
   logic [1:0] idx; // word being loaded
   assign offset = {8'h00, idx, 2'h0};
   // idle data shows an inverted word, not the last one
   assign data = valid ? WORDS[idx] : ~WORDS[0];
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         idx <= 2'h0;
         valid <= 1'b0;
         done <= 1'b0;
      end else if (go && idx == 2'h3) begin
         done <= 1'b1; // release with valid low
      end else if (go && !valid) begin
         valid <= 1'b1;
      end else if (valid && ready) begin
         idx <= idx + 2'h1;
         valid <= !slow && idx != 2'h2; // slow leaves a gap
      end
   end
endmodule : csb_board_ctrl_model
`default_nettype wire

// >>> tb/csb_chip_setup_tb_top.sv
// csb_chip_setup_tb_top: self-checking bench for the chip setup bank
// assumes one 20 MHz clock and the bank as lone AHB-Lite slave
`default_nettype none
module csb_chip_setup_tb_top
   import csb_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [2:0][31:0] LD = {32'h13572468, 32'h0000A5C3, 32'hCFBF8A3C}; // loaded words
   logic CLK;
   logic NRST = 1'b0;
   logic HSEL = 1'b0;
   logic HWRITE = 1'b0;
   logic [1:0] HTRANS = 2'h0;
   logic [2:0] HSIZE = 3'h2;
   logic [31:0] HADDR = 32'h0;
   logic [31:0] HWDATA = 32'h0;
   logic go = 1'b0; // loader start
   logic slow = 1'b0; // loader pace
   wire [31:0] HRDATA, w0, w1, w2, data;
   wire [11:0] offset;
   wire HREADYOUT, HRESP, ready, run, valid, done;
   int errors = 0;
   int compares = 0;
   logic [31:0] rd; // last read word
   logic [2:0][31:0] ex; // expected words
   csb_chip_setup dut (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CFG_LOAD_VALID(valid), .CFG_LOAD_OFFSET(offset),
      .CFG_LOAD_DATA(data), .CFG_LOAD_READY(ready), .CFG_LOAD_DONE(done), .CHIP_RUN(run),
      .CLOCK_DIVIDER_SETUP(w0), .REMAP_AND_MISC_SETUP(w1), .BOOT_OPTION_SETUP(w2));
   csb_board_ctrl_model #(.WORDS(LD)) u_ctrl (.clk(CLK), .nrst(NRST), .go(go), .slow(slow),
      .ready(ready), .valid(valid), .offset(offset), .data(data), .done(done));
   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // one single transfer, each phase held until hready
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] sz);
      HSEL <= 1'b1;
      HTRANS <= CSB_HTRANS_NONSEQ;
      HWRITE <= w;
      HADDR <= {20'h00000, a};
      HSIZE <= sz;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0;
      HSEL <= 1'b0;
      HWDATA <= d;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask : xfer
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0, CSB_HSIZE_WORD);
      check(rd, e);
   endtask : rdchk
   // reset, read defaults, load, release, read loaded words
   task automatic t_load(input logic s);
      NRST <= 1'b0;
      go <= 1'b0;
      slow <= s;
      repeat (8) @(posedge CLK);
      NRST <= 1'b1;
      ex = CSB_RST_VALS;
      for (int i = 0; i < 3; i++) rdchk(12'(i * 4), ex[i]);
      check({31'h0, run}, 32'h0);
      go <= 1'b1;
      while (run !== 1'b1) @(posedge CLK);
      ex = LD;
      for (int i = 0; i < 3; i++) rdchk(12'(i * 4), ex[i]);
      check({31'h0, ready}, 32'h0);
      $display("load test done");
   endtask : t_load
   // read, change some bits, write the whole word back
   task automatic t_rmw();
      for (int i = 0; i < 3; i++) begin
         xfer(1'b0, 12'(i * 4), 32'h0, CSB_HSIZE_WORD);
         ex[i] = rd ^ 32'h00F0000F;
         xfer(1'b1, 12'(i * 4), ex[i], CSB_HSIZE_WORD);
         rdchk(12'(i * 4), ex[i]);
      end
      check(w1, ex[1]);
      $display("read modify write test done");
   endtask : t_rmw
   // narrow, read-only and unused writes change no setup word, only status bits
   task automatic t_bad();
      logic [2:0][11:0] un;
      un = {12'hFFC, 12'h014, 12'h00C};
      xfer(1'b1, CSB_OFF_CLKDIV, 32'hFFFFFFFF, 3'h0);
      xfer(1'b1, 12'h002, 32'hFFFFFFFF, CSB_HSIZE_WORD);
      xfer(1'b1, CSB_OFF_STATUS, 32'hFFFFFFFF, CSB_HSIZE_WORD);
      rdchk(CSB_OFF_STATUS, 32'h0000000D);
      rdchk(CSB_OFF_STATUS, 32'h00000001);
      for (int i = 0; i < 3; i++) xfer(1'b1, un[i], 32'hFFFFFFFF, CSB_HSIZE_WORD);
      rdchk(CSB_OFF_STATUS, 32'h00000003);
      for (int i = 0; i < 3; i++) rdchk(un[i], 32'h0);
      check(w0, ex[0]);
      check(w1, ex[1]);
      check(w2, ex[2]);
      $display("refused write test done");
   endtask : t_bad
   task automatic give_verdict();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   initial begin
      t_load(1'b0);
      t_rmw();
      t_bad();
      t_load(1'b1); // mid-run reset, slow loader
      give_verdict();
   end
   // watchdog well beyond the hundred or so cycles needed
   initial begin
      repeat (3000) @(posedge CLK);
      errors++;
      give_verdict();
   end
endmodule : csb_chip_setup_tb_top
`default_nettype wire
